// file: tc16_ext_model.sv
// Partner model: far-side clock source that sends bursts of pulses
`timescale 1ns/1ps
module tc16_ext_model #(
   parameter int HALF = 6
) (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [7:0] n_pulses,
   output logic pin,
   output logic busy
);
   // Stands low between bursts, so each burst opens with a rise and no fall before it
   // Half period of several ref cycles keeps each level wide enough for two-flop sampling
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (go === 1'b1) begin
            busy <= 1'b1;
            for (int i = 0; i < n_pulses; i++) begin
               repeat (HALF) @(posedge ref_clk);
               pin <= 1'b1;
               repeat (HALF) @(posedge ref_clk);
               pin <= 1'b0;
            end
            busy <= 1'b0;
         end
      end
   end
endmodule

// file: tc16_pkg.sv
// Package: register map, field layout, reset values and shared types of the 16-bit timer
package tc16_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] OFS_CNT_LO = 5'h00;
   localparam logic [4:0] OFS_CNT_HI = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_GATE = 5'h0c;
   localparam logic [4:0] OFS_STAT = 5'h10;

   // Field positions
   localparam int unsigned STAT_OVF_BIT = 0;
   localparam int unsigned STAT_OSC_BIT = 1;
   localparam int unsigned GATE_GE_BIT = 7;
   localparam int unsigned GATE_GVAL_BIT = 2;

   // Values after reset, and the all-ones count that rolls over
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] GSS_RST = 2'h0;
   localparam logic [15:0] CNT_ALL_ONES = 16'hffff;

   // Ref clock cycles per instruction cycle, and the last phase of one
   localparam int unsigned INSTR_CYCLES = 4;
   localparam logic [1:0] PHASE_LAST = 2'(INSTR_CYCLES - 1);

   // Counting source select
   typedef enum logic [1:0] {
      TC16_CS_INSTR = 2'b00,
      TC16_CS_SYS = 2'b01,
      TC16_CS_EXT = 2'b10,
      TC16_CS_CPS = 2'b11
   } tc16_csel_t;

   // Gate source select
   typedef enum logic [1:0] {
      TC16_GS_PIN = 2'b00,
      TC16_GS_CMP1 = 2'b01,
      TC16_GS_CMP2 = 2'b10,
      TC16_GS_NONE = 2'b11
   } tc16_gsel_t;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      tc16_csel_t clock_source_select;
      logic [1:0] prescale_select;
      logic crystal_osc_enable;
      logic sync_disable;
      logic rsv;
      logic counter_on;
   } tc16_ctrl_t;

   // Pins that arrive from outside the ref_clk domain
   typedef struct packed {
      logic ext_clock;
      logic cps_osc;
      logic crystal_in;
      logic gate;
      logic cmp1;
      logic cmp2;
   } tc16_pins_t;

endpackage

// file: tc16_presc.sv
// Prescaler: passes one of every 1, 2, 4 or 8 source ticks
`timescale 1ns/1ps
module tc16_presc #(
   parameter int unsigned PS_W = 2
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic tick_in,
   input wire logic clear,
   input wire logic [PS_W-1:0] sel,
   output logic tick_out
);
   localparam int unsigned CW = (1 << PS_W) - 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
   } tc16_presc_st_t;

   tc16_presc_st_t st_q;
   tc16_presc_st_t st_d;
   logic [CW-1:0] mask;

   // Elaboration guard: wider codes would need a longer hidden counter
   if (PS_W < 1 || PS_W > 4) begin : g_bad_ps_w
      $error("tc16_presc: PS_W must be 1 to 4");
   end

   // Select code n divides by 2**n; counter is hidden from software
   always_comb begin
      mask = CW'((1 << sel) - 1);
      tick_out = tick_in && ((st_q.cnt & mask) == mask);
      st_d = st_q;
      if (clear) begin
         st_d.cnt = '0;
      end else if (tick_in) begin
         st_d.cnt = CW'(st_q.cnt + 1'b1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_presc_clear: assert property (clear |=> st_q.cnt == '0)
      else $error("prescaler not cleared by count write");
   a_presc_div8: assert property ((sel == PS_W'(3)) && tick_out && !clear
      |=> (st_q.cnt & CW'(7)) == CW'(0))
      else $error("divide by eight did not restart after a pass");
endmodule

// file: tc16_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module tc16_sync #(
   parameter int unsigned W = 6
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } tc16_sync_st_t;

   tc16_sync_st_t st_q;
   tc16_sync_st_t st_d;

   // Elaboration guard: an empty bundle has nothing to carry
   if (W < 1) begin : g_bad_width
      $error("tc16_sync: width must be at least one");
   end

   // First stage feeds only the second stage
   always_comb begin
      st_d.meta = async_in;
      st_d.stable = st_q.meta;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.stable;
endmodule

// file: tc16_timer.sv
// Top: 16-bit up-counter with prescaler, gate and Avalon-MM register slave
// What this block does
// - 16-bit up-counter as high and low bytes; writing a byte loads it at once
// - Off when on bit clear; without gate enable counts unless asleep on a synchronous source; else gate decides
// - Source field picks system, instruction, cap-sense, or pin/crystal by oscillator bit
// - Instruction source counts once per instruction cycle; system source four per cycle
// - External sources count on rising edges, synchronised or asynchronous
// - In counter mode a falling edge must precede the first counted rising edge
// - Prescaler divides the selected source by 1, 2, 4 or 8
// - Prescaler hidden from software, cleared by any write to a count byte
// - Oscillator-enable bit starts the crystal oscillator; it keeps running in sleep
// - Sync-disable bit bypasses the extra sync_tick flop; pins still pass the two-flop synchroniser
// - Asynchronous external counting continues in sleep; overflow can wake the processor
// - Mode switches may lose or add one increment; this is tolerated
// - Count can be gated by the gate pin or either comparator output
// - Rollover from all ones sets overflow flag, held until software clears it
// - Gate enabled and gate inactive: counter holds its value
`timescale 1ns/1ps
module tc16_timer (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ext_clock_pin,
   input wire logic cps_osc_pin,
   input wire logic crystal_in_pin,
   output logic crystal_out_pin,
   input wire logic gate_pin,
   input wire logic cmp1_out,
   input wire logic cmp2_out,
   input wire logic cpu_sleep,
   output logic overflow_flag,
   output logic wake_req
);
   typedef struct packed {
      logic [15:0] count;
      tc16_pkg::tc16_ctrl_t ctl;
      logic gate_enable;
      tc16_pkg::tc16_gsel_t gss;
      logic ovf;
      logic armed;
      logic ext_prev;
      logic sync_tick;
      logic [1:0] phase;
      logic xtal_out;
      logic wake;
      logic waitreq;
      logic [31:0] rdata;
   } tc16_state_t;

   tc16_state_t st_q;
   tc16_state_t st_d;
   tc16_pkg::tc16_pins_t pins_raw;
   tc16_pkg::tc16_pins_t pins;
   logic ext_lvl;
   logic is_ext;
   logic gate_lvl;
   logic run;
   logic raw_tick;
   logic ptick;
   logic inc;
   logic rise;
   logic fall;
   logic bus_done;
   logic wr_ok;
   logic cnt_wr;
   logic ovf_set;
   logic ovf_clr;
   logic [7:0] rd_byte;

   // All pin inputs cross into ref_clk before any logic reads them
   assign pins_raw = '{ext_clock: ext_clock_pin, cps_osc: cps_osc_pin,
                       crystal_in: crystal_in_pin, gate: gate_pin,
                       cmp1: cmp1_out, cmp2: cmp2_out};

   tc16_sync #(
      .W(6)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   tc16_presc #(
      .PS_W(2)
   ) u_presc (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .tick_in(raw_tick),
      .clear(cnt_wr),
      .sel(st_q.ctl.prescale_select),
      .tick_out(ptick)
   );

   // Source, gate and enable decode
   always_comb begin
      is_ext = st_q.ctl.clock_source_select[1];
      case (st_q.ctl.clock_source_select)
         tc16_pkg::TC16_CS_EXT: begin
            ext_lvl = st_q.ctl.crystal_osc_enable ? pins.crystal_in : pins.ext_clock;
         end
         tc16_pkg::TC16_CS_CPS: begin
            ext_lvl = pins.cps_osc;
         end
         default: begin
            ext_lvl = 1'b0;
         end
      endcase
      case (st_q.gss)
         tc16_pkg::TC16_GS_PIN: gate_lvl = pins.gate;
         tc16_pkg::TC16_GS_CMP1: gate_lvl = pins.cmp1;
         tc16_pkg::TC16_GS_CMP2: gate_lvl = pins.cmp2;
         default: gate_lvl = 1'b0;
      endcase
      rise = ext_lvl && !st_q.ext_prev;
      fall = !ext_lvl && st_q.ext_prev;
      // Internal clocks stop in sleep; only an asynchronous external source keeps going
      run = st_q.ctl.counter_on && (!st_q.gate_enable || gate_lvl)
            && (!cpu_sleep || (is_ext && st_q.ctl.sync_disable));
   end

   // Per-source tick ahead of the prescaler
   always_comb begin
      case (st_q.ctl.clock_source_select)
         tc16_pkg::TC16_CS_SYS: raw_tick = run;
         tc16_pkg::TC16_CS_INSTR: raw_tick = run && (st_q.phase == tc16_pkg::PHASE_LAST);
         default: raw_tick = run && rise && st_q.armed;
      endcase
      // Synchronous mode adds one flop of delay, so a mode switch may drop or add one count
      if (is_ext && !st_q.ctl.sync_disable) begin
         inc = st_q.sync_tick && run;
      end else begin
         inc = ptick;
      end
   end

   // Bus handshake: first edge lowers waitrequest, second edge completes
   always_comb begin
      bus_done = (avs_read || avs_write) && !st_q.waitreq;
      wr_ok = bus_done && avs_write && avs_byteenable[0];
      cnt_wr = wr_ok && (avs_address == tc16_pkg::OFS_CNT_LO || avs_address == tc16_pkg::OFS_CNT_HI);
      ovf_set = inc && (st_q.count == tc16_pkg::CNT_ALL_ONES);
      ovf_clr = wr_ok && (avs_address == tc16_pkg::OFS_STAT) && avs_writedata[tc16_pkg::STAT_OVF_BIT];
      case (avs_address)
         tc16_pkg::OFS_CNT_LO: rd_byte = st_q.count[7:0];
         tc16_pkg::OFS_CNT_HI: rd_byte = st_q.count[15:8];
         tc16_pkg::OFS_CTRL: rd_byte = st_q.ctl;
         tc16_pkg::OFS_GATE: rd_byte = {st_q.gate_enable, 4'h0, gate_lvl, st_q.gss};
         tc16_pkg::OFS_STAT: rd_byte = {6'h00, st_q.ctl.crystal_osc_enable, st_q.ovf};
         default: rd_byte = 8'h00;
      endcase
   end

   // Next state
   always_comb begin
      st_d = st_q;
      st_d.phase = 2'(st_q.phase + 1'b1);
      st_d.ext_prev = ext_lvl;
      st_d.sync_tick = ptick && is_ext && !st_q.ctl.sync_disable;
      // Count: a byte write beats an increment in the same cycle
      if (cnt_wr) begin
         if (avs_address == tc16_pkg::OFS_CNT_LO) begin
            st_d.count[7:0] = avs_writedata[7:0];
         end else begin
            st_d.count[15:8] = avs_writedata[7:0];
         end
      end else if (inc) begin
         st_d.count = 16'(st_q.count + 1'b1);
      end
      // Edge qualifier is lost on disable or count write
      if (!st_q.ctl.counter_on || cnt_wr) begin
         st_d.armed = 1'b0;
      end else if (fall && is_ext) begin
         st_d.armed = 1'b1;
      end
      // Set wins over a clear in the same cycle
      st_d.ovf = ovf_set || (st_q.ovf && !ovf_clr);
      st_d.wake = ovf_set && cpu_sleep;
      // Crystal amplifier runs whenever enabled, sleep or not
      st_d.xtal_out = st_q.ctl.crystal_osc_enable && !pins.crystal_in;
      if (wr_ok && avs_address == tc16_pkg::OFS_CTRL) begin
         st_d.ctl = avs_writedata[7:0];
         st_d.ctl.rsv = 1'b0;
      end
      if (wr_ok && avs_address == tc16_pkg::OFS_GATE) begin
         st_d.gate_enable = avs_writedata[tc16_pkg::GATE_GE_BIT];
         st_d.gss = tc16_pkg::tc16_gsel_t'(avs_writedata[1:0]);
      end
      if (avs_read || avs_write) begin
         st_d.waitreq = !st_q.waitreq;
         if (st_q.waitreq) begin
            st_d.rdata = {24'h000000, rd_byte};
         end
      end else begin
         st_d.waitreq = 1'b1;
      end
   end

   // One register bank for the whole state; reset loads constants only
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '{count: tc16_pkg::CNT_RST, ctl: tc16_pkg::CTRL_RST, gate_enable: 1'b0,
                   gss: tc16_pkg::TC16_GS_PIN, ovf: 1'b0, armed: 1'b0, ext_prev: 1'b0,
                   sync_tick: 1'b0, phase: 2'h0, xtal_out: 1'b0, wake: 1'b0,
                   waitreq: 1'b1, rdata: 32'h00000000};
      end else begin
         st_q <= st_d;
      end
   end

   // Every output is a flop of the state struct
   assign avs_readdata = st_q.rdata;
   assign avs_waitrequest = st_q.waitreq;
   assign crystal_out_pin = st_q.xtal_out;
   assign overflow_flag = st_q.ovf;
   assign wake_req = st_q.wake;

   // Checks sample on ref_clk and rest while reset is low
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_off_holds: assert property (!st_q.ctl.counter_on && !cnt_wr |=> st_q.count == $past(st_q.count))
      else $error("counter moved while off");
   a_gate_holds: assert property (st_q.gate_enable && !gate_lvl && !cnt_wr
                                  |=> st_q.count == $past(st_q.count))
      else $error("counter moved with gate closed");
   a_sys_rate: assert property (st_q.ctl.counter_on && !st_q.gate_enable && !cpu_sleep && !cnt_wr
      && st_q.ctl.clock_source_select == tc16_pkg::TC16_CS_SYS && st_q.ctl.prescale_select == 2'h0
      |=> st_q.count == 16'($past(st_q.count) + 1'b1))
      else $error("system clock source missed a count");
   a_instr_rate: assert property (st_q.ctl.clock_source_select == tc16_pkg::TC16_CS_INSTR
      && st_q.phase != tc16_pkg::PHASE_LAST && !cnt_wr |=> st_q.count == $past(st_q.count))
      else $error("instruction source counted mid cycle");
   a_low_write: assert property (cnt_wr && avs_address == tc16_pkg::OFS_CNT_LO
                                 |=> st_q.count[7:0] == $past(avs_writedata[7:0]))
      else $error("low byte write not loaded");
   a_write_disarms: assert property (cnt_wr |=> !st_q.armed)
      else $error("edge qualifier kept across a count write");
   a_unarmed_no_inc: assert property (is_ext && st_q.ctl.sync_disable && !st_q.armed && !cnt_wr
                                      |=> st_q.count == $past(st_q.count))
      else $error("counted a rising edge without a prior falling edge");
   a_ovf_sets: assert property (ovf_set |=> st_q.ovf ##1 st_q.ovf || $past(ovf_clr))
      else $error("overflow flag not set on rollover");
   a_flag_sticky: assert property (st_q.ovf && !ovf_clr |=> st_q.ovf)
      else $error("overflow flag dropped without a clear");
   a_sleep_freeze: assert property (cpu_sleep && !(is_ext && st_q.ctl.sync_disable) && !cnt_wr
      && !(st_q.sync_tick && st_q.ctl.counter_on) |=> st_q.count == $past(st_q.count))
      else $error("synchronous source counted during sleep");
   a_bus_answer: assert property ((avs_read || avs_write) && st_q.waitreq |=> !st_q.waitreq)
      else $error("waitrequest not lowered one cycle after request");
   a_xtal_runs: assert property (!st_q.ctl.crystal_osc_enable ##1 !st_q.ctl.crystal_osc_enable
                                 |-> !st_q.xtal_out)
      else $error("crystal amplifier driven while disabled");

   // Byte loads and write priority
   a_high_write: assert property (cnt_wr && avs_address == tc16_pkg::OFS_CNT_HI
      |=> st_q.count[15:8] == $past(avs_writedata[7:0]))
      else $error("high byte write not loaded");
   a_write_wins: assert property (cnt_wr && inc && avs_address == tc16_pkg::OFS_CNT_LO
      |=> st_q.count[15:8] == $past(st_q.count[15:8]))
      else $error("increment leaked past a low byte write");
   a_ctrl_write: assert property (wr_ok && avs_address == tc16_pkg::OFS_CTRL
      |=> st_q.ctl.counter_on == $past(avs_writedata[0]))
      else $error("on bit not taken from control write");
   a_rsv_zero: assert property (!st_q.ctl.rsv)
      else $error("spare control bit stored");

   // Gate decides only while gate enable is set
   a_gate_open: assert property (st_q.ctl.counter_on && st_q.gate_enable
      && gate_lvl && !cpu_sleep && !cnt_wr && st_q.ctl.prescale_select == 2'h0
      && st_q.ctl.clock_source_select == tc16_pkg::TC16_CS_SYS
      |=> st_q.count == 16'($past(st_q.count) + 1'b1))
      else $error("open gate stopped the count");
   a_gate_none: assert property (st_q.gate_enable && !cnt_wr
      && st_q.gss == tc16_pkg::TC16_GS_NONE |=> st_q.count == $past(st_q.count))
      else $error("gate source none let the count run");

   // Edge qualifier life cycle
   a_fall_arms: assert property (st_q.ctl.counter_on && is_ext && fall && !cnt_wr
      |=> st_q.armed)
      else $error("falling edge did not arm the counter");
   a_off_disarms: assert property (!st_q.ctl.counter_on |=> !st_q.armed)
      else $error("edge qualifier kept while off");

   // External edges: direct when asynchronous, one flop later when synchronous
   a_async_edge: assert property (run && rise && st_q.armed && !cnt_wr
      && is_ext && st_q.ctl.sync_disable && st_q.ctl.prescale_select == 2'h0
      |=> st_q.count == 16'($past(st_q.count) + 1'b1))
      else $error("asynchronous edge not counted");
   a_sync_edge: assert property (run && ptick && is_ext && !cnt_wr
      && !st_q.ctl.sync_disable ##1 run && is_ext && !st_q.ctl.sync_disable && !cnt_wr
      |=> st_q.count == 16'($past(st_q.count) + 1'b1))
      else $error("synchronised edge not counted one cycle later");
   a_sync_no_direct: assert property (is_ext && !st_q.sync_tick && !cnt_wr
      && !st_q.ctl.sync_disable |=> st_q.count == $past(st_q.count))
      else $error("synchronous mode counted without the extra flop");

   // Overflow flag, wake pulse and asynchronous count in sleep
   a_ovf_cause: assert property ($rose(st_q.ovf)
      |-> $past(st_q.count) == tc16_pkg::CNT_ALL_ONES)
      else $error("overflow flag set without a rollover");
   a_ovf_clears: assert property (ovf_clr && !ovf_set |=> !st_q.ovf)
      else $error("overflow flag not cleared by software");
   a_set_wins: assert property (ovf_set && ovf_clr |=> st_q.ovf)
      else $error("clear beat a rollover in the same cycle");
   a_wake_cause: assert property (st_q.wake
      |-> $past(cpu_sleep) && $past(ovf_set))
      else $error("wake pulse without a rollover in sleep");
   a_sleep_async: assert property (cpu_sleep && rise && st_q.armed && !cnt_wr
      && st_q.ctl.counter_on && !st_q.gate_enable && is_ext && st_q.ctl.sync_disable
      && st_q.ctl.prescale_select == 2'h0 |=> st_q.count == 16'($past(st_q.count) + 1'b1))
      else $error("asynchronous count stopped in sleep");

   // Instruction source: one count on the last phase
   a_instr_count: assert property (st_q.ctl.counter_on && !st_q.gate_enable
      && !cpu_sleep && !cnt_wr && st_q.ctl.clock_source_select == tc16_pkg::TC16_CS_INSTR
      && st_q.ctl.prescale_select == 2'h0 && st_q.phase == tc16_pkg::PHASE_LAST
      |=> st_q.count == 16'($past(st_q.count) + 1'b1))
      else $error("instruction source missed its count");

   // Amplifier follows the crystal whenever enabled, asleep or awake
   a_xtal_drive: assert property (st_q.ctl.crystal_osc_enable && !pins.crystal_in
      |=> st_q.xtal_out)
      else $error("crystal amplifier not driven while enabled");

   // Bus idles with waitrequest high and upper read bits zero
   a_bus_idle: assert property (!avs_read && !avs_write |=> st_q.waitreq)
      else $error("waitrequest low with no request");
   a_rdata_upper: assert property (st_q.rdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");

   c_overflow: cover property (ovf_set);
   c_async_sleep: cover property (cpu_sleep && inc && st_q.ctl.sync_disable);
   c_gated_count: cover property (st_q.gate_enable && gate_lvl && inc);
   c_sync_ext: cover property (is_ext && !st_q.ctl.sync_disable && inc);
   c_wake: cover property (st_q.wake);
endmodule

// file: tc16_timer_tb.sv
// Testbench: register-level tests of the 16-bit timer through its bus and pins
`timescale 1ns/1ps
module tc16_timer_tb;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic crystal_out_pin;
   logic overflow_flag;
   logic wake_req;
   logic gate_pin = 1'b0;
   logic cmp1_out = 1'b0;
   logic cmp2_out = 1'b0;
   logic cpu_sleep = 1'b0;
   logic [2:0] go = 3'h0;
   wire [2:0] pins;
   wire [2:0] busy;
   logic [7:0] n_pulses = 8'h00;
   logic [7:0] d;
   logic [15:0] cnt;
   logic [7:0] tc [6] = '{8'h81, 8'h85, 8'hc1, 8'h89, 8'h89, 8'h81};
   int ts [6] = '{0, 0, 1, 2, 0, 2};
   int te [6] = '{4, 4, 4, 4, 0, 0};
   int n_errors = 0;
   int num_checks = 0;
   int n_wake = 0;
   int w0;

   // 40 MHz reference
   always #12.5 ref_clk = ~ref_clk;

   // Tally wake pulses
   always @(posedge ref_clk) if (wake_req === 1'b1) n_wake <= n_wake + 1;

   tc16_timer dut (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_clock_pin(pins[0]),
      .cps_osc_pin(pins[1]), .crystal_in_pin(pins[2]), .crystal_out_pin, .gate_pin,
      .cmp1_out, .cmp2_out, .cpu_sleep, .overflow_flag, .wake_req);

   // Pin source 0, cap-sense source 1, crystal source 2
   for (genvar k = 0; k < 3; k++) begin : g_src
      tc16_ext_model m (.ref_clk, .go(go[k]), .n_pulses, .pin(pins[k]), .busy(busy[k]));
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic fail(input string m);
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
   endtask

   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
      int i;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, wd};
      avs_write <= wr;
      avs_read <= ~wr;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      d = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         fail("bus timeout");
         end_of_test();
      end
   endtask

   // Count compare with a tolerance for bus-edge alignment
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
      logic ok;
      num_checks++;
      ok = (got + tol >= exp) && (got <= exp + tol);
      if (ok !== 1'b1) fail($sformatf("got %h exp %h", got, exp));
   endtask

   // Preload, arm, count for a while, stop, read back; window is cyc+3 edges
   task automatic run(input logic [7:0] c, input logic [15:0] pre, input int src,
      input int cyc, input logic slp);
      int i;
      bus(1'b1, tc16_pkg::OFS_CNT_LO, pre[7:0]); // Counter is off here
      bus(1'b1, tc16_pkg::OFS_CNT_HI, pre[15:8]);
      bus(1'b1, tc16_pkg::OFS_CTRL, c & 8'hfe);
      repeat (8) @(posedge ref_clk); // Let the source settle before on
      bus(1'b1, tc16_pkg::OFS_CTRL, c);
      cpu_sleep <= slp;
      if (src < 0) repeat (cyc) @(posedge ref_clk);
      else begin
         n_pulses <= 8'(cyc);
         go[src] <= 1'b1;
         @(posedge ref_clk);
         go[src] <= 1'b0;
         i = 0;
         do begin
            @(posedge ref_clk);
            i++;
         end while (busy[src] !== 1'b0 && i < 2000);
         if (busy[src] !== 1'b0) begin
            fail("source hang");
            end_of_test();
         end
      end
      bus(1'b1, tc16_pkg::OFS_CTRL, c & 8'hfe);
      cpu_sleep <= 1'b0; // Wake only once stopped, so no count slips in
      bus(1'b0, tc16_pkg::OFS_CNT_LO, 8'h00);
      cnt[7:0] = d;
      bus(1'b0, tc16_pkg::OFS_CNT_HI, 8'h00);
      cnt[15:8] = d;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 24; a += 4) begin
         bus(1'b0, 5'(a), 8'h00);
         chk(16'(d), 16'h0, 0); // Reset values and unmapped hole
      end
      bus(1'b1, tc16_pkg::OFS_CNT_LO, 8'h34);
      bus(1'b1, tc16_pkg::OFS_CNT_HI, 8'h12);
      repeat (20) @(posedge ref_clk);
      run(8'h00, 16'h1234, -1, 30, 1'b0);
      chk(cnt, 16'h1234, 0); // Bytes load, off holds
      $display("test reset done");
      bus(1'b1, tc16_pkg::OFS_CTRL, 8'h0a);
      bus(1'b0, tc16_pkg::OFS_CTRL, 8'h00);
      chk(16'(d), 16'h08, 0); // Spare bit reads zero
      bus(1'b0, tc16_pkg::OFS_STAT, 8'h00);
      chk(16'(d), 16'h02, 0); // Oscillator running status
      chk(16'(crystal_out_pin), 16'h1, 0); // Amplifier drives inverse
      bus(1'b1, tc16_pkg::OFS_CTRL, 8'h00);
      $display("test crystal done");
      for (int p = 0; p < 4; p++) begin
         run({2'b01, 2'(p), 4'h1}, 16'h0, -1, 61, 1'b0);
         chk(cnt, 16'(64 >> p), 2); // System rate per prescale code
      end
      run(8'h01, 16'h0, -1, 61, 1'b0);
      chk(cnt, 16'd16, 2); // Instruction rate is a quarter
      run(8'h41, 16'h0, -1, 61, 1'b1);
      chk(cnt, 16'h0, 2); // Synchronous count frozen in sleep
      $display("test rates done");
      gate_pin <= 1'b1;
      cmp1_out <= 1'b0;
      cmp2_out <= 1'b1;
      for (int g = 0; g < 5; g++) begin
         bus(1'b1, tc16_pkg::OFS_GATE, g < 4 ? {6'h20, 2'(g)} : 8'h03);
         run(8'h41, 16'h0, -1, 61, 1'b0);
         chk(cnt, (g == 1 || g == 3) ? 16'h0 : 16'd64, (g == 1 || g == 3) ? 0 : 2); // Gate
      end
      bus(1'b1, tc16_pkg::OFS_GATE, 8'h00);
      $display("test gate done");
      run(8'h41, 16'hfffd, -1, 7, 1'b0);
      chk(cnt, 16'h7, 2); // Rolls through zero
      chk(16'(overflow_flag), 16'h1, 0); // Flag raised on rollover
      repeat (20) @(posedge ref_clk);
      bus(1'b0, tc16_pkg::OFS_STAT, 8'h00);
      chk(16'(d[0]), 16'h1, 0); // Flag still held
      bus(1'b1, tc16_pkg::OFS_STAT, 8'h01);
      bus(1'b0, tc16_pkg::OFS_STAT, 8'h00);
      chk(16'(d[0]), 16'h0, 0); // Cleared by software
      $display("test overflow done");
      // First rise after a byte write counts only if a falling edge precedes it
      for (int k = 0; k < 6; k++) begin
         run(tc[k], 16'h0, ts[k], 5, 1'b0);
         chk(cnt, 16'(te[k]), 0); // Source select and edges
      end
      $display("test external done");
      w0 = n_wake;
      run(8'h85, 16'hffff, 0, 3, 1'b1);
      chk(cnt, 16'h1, 0); // Asynchronous count runs in sleep
      chk(16'(n_wake - w0), 16'h1, 0); // One wake pulse on rollover
      $display("test sleep done");
      end_of_test();
   end

   // Watchdog on the whole run
   initial begin
      repeat (100000) @(posedge ref_clk);
      fail("run too long");
      end_of_test();
   end
endmodule
